// >>> verilog/bpc_pkg.sv
/*
  Constants, field layouts and carrier types of the bridge primary command block.
  Assumes a byte-addressed configuration port that moves 16-bit words at even offsets.
*/
// Summary of operation
// RQ1: Fast back-to-back enable, bit 9, is read-only and reads zero.
// RQ2: Address/data stepping, bit 7, always reads zero.
// RQ3: Parity error response enable, bit 6, always reads zero.
// RQ4: Write-and-invalidate bit 4 and special-cycle bit 3 are hardwired to zero.
// RQ5: With bit 8 set, send system-error messages for individually enabled bridge errors.
// RQ6: With bit 8 clear, never send a system-error message for this function.
// RQ7: Report the system-error condition in the primary status register.
// RQ8: Bus master enable, bit 2, resets to zero; then master cycles end in abort.
// RQ9: With bus master enable set, accept master cycles only in a valid range.
// RQ10: Sideband and pipelined requests are served whatever bus master enable holds.
// RQ11: Memory decode enable, bit 1, clear means no bridge memory space decodes.
// RQ12: Memory decode enable set decodes the memory and prefetchable windows.
// RQ13: I/O decode enable, bit 0, clear means no bridge I/O space decodes.
// RQ14: I/O decode enable set decodes the I/O window.
// RQ15: Bits 15 to 10 and bit 5 read zero and ignore writes.
// RQ16: Sending a system-error message sets status bit 14; writing one clears it.
package bpc_pkg;

  // Register offsets on the configuration port.
  localparam logic [7:0] BPC_CMD_OFFSET = 8'h04;
  localparam logic [7:0] BPC_STS_OFFSET = 8'h06;

  // Field positions of the command register.
  localparam int BPC_IO_EN_BIT = 0;
  localparam int BPC_MEM_EN_BIT = 1;
  localparam int BPC_BM_EN_BIT = 2;
  localparam int BPC_SPECIAL_BIT = 3;
  localparam int BPC_MWI_BIT = 4;
  localparam int BPC_PERR_BIT = 6;
  localparam int BPC_STEP_BIT = 7;
  localparam int BPC_SERR_EN_BIT = 8;
  localparam int BPC_FAST_B2B_BIT = 9;

  // Field position of the signaled system error flag in the status register.
  localparam int BPC_SSE_BIT = 14;

  // Reset values and the fixed part of the status word.
  localparam logic [15:0] BPC_CMD_RESET = 16'h0000;
  localparam logic [15:0] BPC_STS_RESET = 16'h00A0;
  localparam logic [15:0] BPC_STS_FIXED = 16'h00A0;
  localparam logic [15:0] BPC_CMD_RW_MASK = 16'h0107;

  // Default widths.
  localparam int BPC_ADDR_W = 32;
  localparam int BPC_ERR_N = 4;

  // Command register as it reads on the port.
  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic fast_b2b_enable;
    logic syserr_msg_enable;
    logic addr_data_stepping;
    logic parity_resp_enable;
    logic rsvd_5;
    logic write_invalidate_enable;
    logic special_cycle_enable;
    logic bus_master_enable;
    logic memory_decode_enable;
    logic io_decode_enable;
  } bpc_cmd_s;

  // One address window from its base and limit registers.
  typedef struct packed {
    logic [BPC_ADDR_W-1:0] base;
    logic [BPC_ADDR_W-1:0] limit;
  } bpc_win_s;

  // One configuration request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] be;
    logic [7:0] addr;
    logic [15:0] wdata;
  } bpc_cfg_s;

endpackage : bpc_pkg

// >>> verilog/bpc_window_cmp.sv
/*
  Address window compare used for each decode window of the bridge.
  Assumes base and limit are held steady by their registers while compared.
*/
`timescale 1ns/100ps
module bpc_window_cmp #(
  parameter int ADDR_W = 32
) (
  // Window and enable.
  input wire logic [ADDR_W-1:0] base_in,
  input wire logic [ADDR_W-1:0] limit_in,
  input wire logic enable_in,
  // Address under test.
  input wire logic [ADDR_W-1:0] addr_in,
  // Result.
  output logic hit_out
);

  // A base above the limit gives an empty window, which is how software turns one off.
  always_comb begin
    hit_out = enable_in && (addr_in >= base_in) && (addr_in <= limit_in);
  end

endmodule : bpc_window_cmp

// >>> verilog/bpc_command.sv
/*
  Primary command register of the virtual bridge, with the status flag it reports,
  the system-error message gate, the bus master gate and the window decode gates.
  Assumes error events, requests and windows come from logic on mclk_in.
*/
`timescale 1ns/100ps
module bpc_command #(
  parameter int ADDR_W = bpc_pkg::BPC_ADDR_W,
  parameter int ERR_N = bpc_pkg::BPC_ERR_N
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Configuration port.
  input wire bpc_pkg::bpc_cfg_s cfg_in,
  output logic [15:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Error sources and their individual enables.
  input wire logic [ERR_N-1:0] err_event_in,
  input wire logic [ERR_N-1:0] err_enable_in,
  output logic syserr_msg_out,
  // Master cycles from the AGP side.
  input wire logic frame_start_in,
  input wire logic frame_range_ok_in,
  output logic frame_accept_out,
  output logic frame_master_abort_out,
  // Sideband and pipelined requests.
  input wire logic pipe_req_in,
  output logic pipe_accept_out,
  // Host cycles decoded against the bridge windows.
  input wire logic host_req_in,
  input wire logic host_is_io_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire bpc_pkg::bpc_win_s mem_win_in,
  input wire bpc_pkg::bpc_win_s pref_win_in,
  input wire bpc_pkg::bpc_win_s io_win_in,
  output logic mem_hit_out,
  output logic io_hit_out,
  // Enables seen by the rest of the bridge.
  output logic bus_master_enable_out,
  output logic memory_decode_enable_out,
  output logic io_decode_enable_out
);
  import bpc_pkg::*;

  // Only the writable command bits are stored; every hardwired bit is a constant.
  logic syserr_en_reg, syserr_en_next;
  logic bm_en_reg, bm_en_next;
  logic mem_en_reg, mem_en_next;
  logic io_en_reg, io_en_next;
  logic sse_reg, sse_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic rd_cmd_reg, rd_cmd_next;
  logic rd_sts_reg, rd_sts_next;
  logic msg_reg, msg_next;
  logic accept_reg, accept_next;
  logic abort_reg, abort_next;
  logic pipe_reg, pipe_next;
  logic mem_hit_reg, mem_hit_next;
  logic io_hit_reg, io_hit_next;

  bpc_cmd_s cmd_view;
  logic [15:0] sts_view;
  logic wr_cmd, wr_sts, err_hit;
  logic mem_win_hit, pref_win_hit, io_win_hit;

  // Read view of the command word.
  always_comb begin
    cmd_view = bpc_cmd_s'(BPC_CMD_RESET);
    // RQ15 reserved read zero.
    cmd_view.rsvd_hi = 6'h00;
    cmd_view.rsvd_5 = 1'b0;
    // RQ1 fast back-to-back zero.
    cmd_view.fast_b2b_enable = 1'b0;
    // RQ2 stepping reads zero.
    cmd_view.addr_data_stepping = 1'b0;
    // RQ3 parity enable zero.
    cmd_view.parity_resp_enable = 1'b0;
    // RQ4 hardwired enables zero.
    cmd_view.write_invalidate_enable = 1'b0;
    cmd_view.special_cycle_enable = 1'b0;
    cmd_view.syserr_msg_enable = syserr_en_reg;
    cmd_view.bus_master_enable = bm_en_reg;
    cmd_view.memory_decode_enable = mem_en_reg;
    cmd_view.io_decode_enable = io_en_reg;
  end

  // Status word: fixed capability bits plus the one flag this block owns.
  always_comb begin
    sts_view = BPC_STS_FIXED;
    // RQ7 status shows condition.
    sts_view[BPC_SSE_BIT] = sse_reg;
  end

  // Address decode of the two registers.
  assign wr_cmd = cfg_in.wr && (cfg_in.addr == BPC_CMD_OFFSET);
  assign wr_sts = cfg_in.wr && (cfg_in.addr == BPC_STS_OFFSET);

  // Any individually enabled error condition this cycle.
  assign err_hit = |(err_event_in & err_enable_in);

  // Window compares; the enable input gates each one at the source.
  bpc_window_cmp #(
    .ADDR_W(ADDR_W)
  ) u_mem_win (
    .base_in(mem_win_in.base),
    .limit_in(mem_win_in.limit),
    .enable_in(mem_en_reg),
    .addr_in(host_addr_in),
    .hit_out(mem_win_hit)
  );

  bpc_window_cmp #(
    .ADDR_W(ADDR_W)
  ) u_pref_win (
    .base_in(pref_win_in.base),
    .limit_in(pref_win_in.limit),
    .enable_in(mem_en_reg),
    .addr_in(host_addr_in),
    .hit_out(pref_win_hit)
  );

  bpc_window_cmp #(
    .ADDR_W(ADDR_W)
  ) u_io_win (
    .base_in(io_win_in.base),
    .limit_in(io_win_in.limit),
    .enable_in(io_en_reg),
    .addr_in(host_addr_in),
    .hit_out(io_win_hit)
  );

  // Register writes; the low byte lane holds bits 7:0, the high lane bits 15:8.
  always_comb begin
    syserr_en_next = syserr_en_reg;
    bm_en_next = bm_en_reg;
    mem_en_next = mem_en_reg;
    io_en_next = io_en_reg;
    sse_next = sse_reg;
    if (wr_cmd && cfg_in.be[0]) begin
      bm_en_next = cfg_in.wdata[BPC_BM_EN_BIT];
      mem_en_next = cfg_in.wdata[BPC_MEM_EN_BIT];
      io_en_next = cfg_in.wdata[BPC_IO_EN_BIT];
    end
    if (wr_cmd && cfg_in.be[1]) begin
      syserr_en_next = cfg_in.wdata[BPC_SERR_EN_BIT];
    end
    // RQ16 write one clears.
    if (wr_sts && cfg_in.be[1] && cfg_in.wdata[BPC_SSE_BIT]) begin
      sse_next = 1'b0;
    end
    // RQ16 set beats clear.
    if (msg_next) begin
      sse_next = 1'b1;
    end
  end

  // System-error message gate, computed from the enable as it stands this cycle.
  always_comb begin
    // RQ5 enabled errors signal.
    // RQ6 gate blocks messages.
    msg_next = syserr_en_reg && err_hit;
  end

  // Register reads answer one cycle later; a read beside a write sees the old value.
  always_comb begin
    rdata_next = 16'h0000;
    rd_cmd_next = 1'b0;
    rd_sts_next = 1'b0;
    rvalid_next = cfg_in.rd;
    if (cfg_in.rd && (cfg_in.addr == BPC_CMD_OFFSET)) begin
      rdata_next = cmd_view & BPC_CMD_RW_MASK;
      rd_cmd_next = 1'b1;
    end else if (cfg_in.rd && (cfg_in.addr == BPC_STS_OFFSET)) begin
      rdata_next = sts_view;
      rd_sts_next = 1'b1;
    end
  end

  // Request gates toward the AGP side.
  always_comb begin
    // RQ8 disabled master aborts.
    // RQ9 accept in range.
    accept_next = frame_start_in && bm_en_reg && frame_range_ok_in;
    abort_next = frame_start_in && !(bm_en_reg && frame_range_ok_in);
    // RQ10 pipelined requests unaffected.
    pipe_next = pipe_req_in;
  end

  // Host decode results.
  always_comb begin
    // RQ11 memory decode gated.
    // RQ12 both memory windows.
    mem_hit_next = host_req_in && !host_is_io_in && (mem_win_hit || pref_win_hit);
    // RQ13 io decode gated.
    // RQ14 io window decode.
    io_hit_next = host_req_in && host_is_io_in && io_win_hit;
  end

  // State registers with synchronous reset.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      // RQ8 master enable resets clear.
      syserr_en_reg <= BPC_CMD_RESET[BPC_SERR_EN_BIT];
      bm_en_reg <= BPC_CMD_RESET[BPC_BM_EN_BIT];
      mem_en_reg <= BPC_CMD_RESET[BPC_MEM_EN_BIT];
      io_en_reg <= BPC_CMD_RESET[BPC_IO_EN_BIT];
      sse_reg <= BPC_STS_RESET[BPC_SSE_BIT];
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      rd_cmd_reg <= 1'b0;
      rd_sts_reg <= 1'b0;
      msg_reg <= 1'b0;
      accept_reg <= 1'b0;
      abort_reg <= 1'b0;
      pipe_reg <= 1'b0;
      mem_hit_reg <= 1'b0;
      io_hit_reg <= 1'b0;
    end else begin
      syserr_en_reg <= syserr_en_next;
      bm_en_reg <= bm_en_next;
      mem_en_reg <= mem_en_next;
      io_en_reg <= io_en_next;
      sse_reg <= sse_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      rd_cmd_reg <= rd_cmd_next;
      rd_sts_reg <= rd_sts_next;
      msg_reg <= msg_next;
      accept_reg <= accept_next;
      abort_reg <= abort_next;
      pipe_reg <= pipe_next;
      mem_hit_reg <= mem_hit_next;
      io_hit_reg <= io_hit_next;
    end
  end

  // Every output comes straight from a flip-flop.
  assign cfg_rdata_out = rdata_reg;
  assign cfg_rvalid_out = rvalid_reg;
  assign syserr_msg_out = msg_reg;
  assign frame_accept_out = accept_reg;
  assign frame_master_abort_out = abort_reg;
  assign pipe_accept_out = pipe_reg;
  assign mem_hit_out = mem_hit_reg;
  assign io_hit_out = io_hit_reg;
  assign bus_master_enable_out = bm_en_reg;
  assign memory_decode_enable_out = mem_en_reg;
  assign io_decode_enable_out = io_en_reg;

  // Checks on the command word as it reads back.
  property p_fast_b2b_zero;
    @(posedge mclk_in) disable iff (rst_in)
      cfg_rvalid_out && rd_cmd_reg |-> !cfg_rdata_out[BPC_FAST_B2B_BIT];
  endproperty
  a_fast_b2b_zero: assert property (p_fast_b2b_zero) // RQ1
    else $error("fast back-to-back bit read as one");

  property p_step_zero;
    @(posedge mclk_in) disable iff (rst_in)
      cfg_in.rd && cfg_in.addr == BPC_CMD_OFFSET |=> !cfg_rdata_out[BPC_STEP_BIT];
  endproperty
  a_step_zero: assert property (p_step_zero) // RQ2
    else $error("stepping bit read as one");

  property p_perr_zero;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(rd_cmd_reg) |-> cfg_rvalid_out && !cfg_rdata_out[BPC_PERR_BIT];
  endproperty
  a_perr_zero: assert property (p_perr_zero) // RQ3
    else $error("parity enable read as one");

  property p_mwi_special_zero;
    @(posedge mclk_in) disable iff (rst_in)
      rd_cmd_reg |-> cfg_rdata_out[BPC_MWI_BIT:BPC_SPECIAL_BIT] == 2'b00;
  endproperty
  a_mwi_special_zero: assert property (p_mwi_special_zero) // RQ4
    else $error("hardwired enables read as one");

  property p_rsvd_zero;
    @(posedge mclk_in) disable iff (rst_in)
      rd_cmd_reg |-> (cfg_rdata_out & ~BPC_CMD_RW_MASK) == 16'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // RQ15
    else $error("reserved command bits read as one");

  // Checks on system-error messaging and its status flag.
  property p_msg_sent;
    @(posedge mclk_in) disable iff (rst_in)
      syserr_en_reg && err_hit |=> syserr_msg_out && sse_reg;
  endproperty
  a_msg_sent: assert property (p_msg_sent) // RQ5
    else $error("enabled error gave no system-error message");

  property p_msg_blocked;
    @(posedge mclk_in) disable iff (rst_in)
      !syserr_en_reg |=> !syserr_msg_out;
  endproperty
  a_msg_blocked: assert property (p_msg_blocked) // RQ6
    else $error("message sent while gate was off");

  property p_sts_report;
    @(posedge mclk_in) disable iff (rst_in)
      cfg_in.rd && cfg_in.addr == BPC_STS_OFFSET |=> cfg_rdata_out[BPC_SSE_BIT] == $past(sse_reg);
  endproperty
  a_sts_report: assert property (p_sts_report) // RQ7
    else $error("status read does not show the flag");

  property p_sse_clear;
    @(posedge mclk_in) disable iff (rst_in)
      wr_sts && cfg_in.be[1] && cfg_in.wdata[BPC_SSE_BIT] && !msg_next |=> !sse_reg;
  endproperty
  a_sse_clear: assert property (p_sse_clear) // RQ16
    else $error("write of one did not clear the flag");

  // Checks on the AGP side gates.
  property p_bm_abort;
    @(posedge mclk_in) disable iff (rst_in)
      frame_start_in && !bus_master_enable_out |=> frame_master_abort_out && !frame_accept_out;
  endproperty
  a_bm_abort: assert property (p_bm_abort) // RQ8
    else $error("master cycle not aborted while disabled");

  property p_bm_accept;
    @(posedge mclk_in) disable iff (rst_in)
      frame_start_in && bus_master_enable_out && frame_range_ok_in |=> frame_accept_out;
  endproperty
  a_bm_accept: assert property (p_bm_accept) // RQ9
    else $error("master cycle in range not accepted");

  property p_pipe_free;
    @(posedge mclk_in) disable iff (rst_in)
      pipe_req_in |=> pipe_accept_out;
  endproperty
  a_pipe_free: assert property (p_pipe_free) // RQ10
    else $error("pipelined request not served");

  // Checks on host decode.
  property p_mem_off;
    @(posedge mclk_in) disable iff (rst_in)
      !memory_decode_enable_out |=> !mem_hit_out;
  endproperty
  a_mem_off: assert property (p_mem_off) // RQ11
    else $error("memory hit while memory decode off");

  property p_mem_on;
    @(posedge mclk_in) disable iff (rst_in)
      host_req_in && !host_is_io_in && memory_decode_enable_out
      && host_addr_in >= pref_win_in.base && host_addr_in <= pref_win_in.limit |=> mem_hit_out;
  endproperty
  a_mem_on: assert property (p_mem_on) // RQ12
    else $error("prefetchable window not decoded");

  property p_io_off;
    @(posedge mclk_in) disable iff (rst_in)
      !io_decode_enable_out |=> !io_hit_out;
  endproperty
  a_io_off: assert property (p_io_off) // RQ13
    else $error("io hit while io decode off");

  property p_io_on;
    @(posedge mclk_in) disable iff (rst_in)
      host_req_in && host_is_io_in && io_decode_enable_out
      && host_addr_in >= io_win_in.base && host_addr_in <= io_win_in.limit |=> io_hit_out;
  endproperty
  a_io_on: assert property (p_io_on) // RQ14
    else $error("io window not decoded");

endmodule : bpc_command

// >>> sim/bpc_command_tb.sv
/*
  Self-checking testbench of the bridge primary command block.
  Assumes the block alone is under test; the bench drives every input on the falling edge.
*/
`timescale 1ns/100ps
module bpc_command_tb;
  import bpc_pkg::*;

  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  bpc_cfg_s cfg_in = '0;
  logic [15:0] cfg_rdata_out;
  logic cfg_rvalid_out;
  logic [3:0] err_event_in = 4'h0;
  logic [3:0] err_enable_in = 4'h0;
  logic syserr_msg_out;
  logic frame_start_in = 1'b0;
  logic frame_range_ok_in = 1'b0;
  logic frame_accept_out;
  logic frame_master_abort_out;
  logic pipe_req_in = 1'b0;
  logic pipe_accept_out;
  logic host_req_in = 1'b0;
  logic host_is_io_in = 1'b0;
  logic [31:0] host_addr_in = 32'h0000_0000;
  bpc_win_s mem_win_in = '{32'h0000_1000, 32'h0000_1FFF};
  bpc_win_s pref_win_in = '{32'h0000_8000, 32'h0000_8FFF};
  bpc_win_s io_win_in = '{32'h0000_0100, 32'h0000_01FF};
  logic mem_hit_out;
  logic io_hit_out;
  logic bus_master_enable_out;
  logic memory_decode_enable_out;
  logic io_decode_enable_out;
  int err_count = 0;
  int n_checks = 0;

  // Free-running 20 MHz clock.
  always #25 mclk_in = ~mclk_in;

  bpc_command #(.ADDR_W(32), .ERR_N(4)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .cfg_in(cfg_in), .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
    .err_event_in(err_event_in), .err_enable_in(err_enable_in),
    .syserr_msg_out(syserr_msg_out),
    .frame_start_in(frame_start_in), .frame_range_ok_in(frame_range_ok_in),
    .frame_accept_out(frame_accept_out), .frame_master_abort_out(frame_master_abort_out),
    .pipe_req_in(pipe_req_in), .pipe_accept_out(pipe_accept_out),
    .host_req_in(host_req_in), .host_is_io_in(host_is_io_in), .host_addr_in(host_addr_in),
    .mem_win_in(mem_win_in), .pref_win_in(pref_win_in), .io_win_in(io_win_in),
    .mem_hit_out(mem_hit_out), .io_hit_out(io_hit_out),
    .bus_master_enable_out(bus_master_enable_out),
    .memory_decode_enable_out(memory_decode_enable_out),
    .io_decode_enable_out(io_decode_enable_out)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Compares one settled value with its expectation.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write, then one idle cycle so the next call never re-drives the port at once.
  task automatic cfg_wr(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] data);
    cfg_in = '{1'b1, 1'b0, be, addr, data};
    @(negedge mclk_in);
    cfg_in = '0;
    @(negedge mclk_in);
  endtask : cfg_wr

  // One-cycle read; data stands for one cycle, sampled mid-cycle after the taking edge.
  task automatic cfg_rd(input logic [7:0] addr, input logic [15:0] exp);
    cfg_in = '{1'b0, 1'b1, 2'h3, addr, 16'h0000};
    @(negedge mclk_in);
    cfg_in = '0;
    chk({15'h0000, cfg_rvalid_out}, 16'h0001);
    chk(cfg_rdata_out, exp);
    @(negedge mclk_in);
  endtask : cfg_rd

  // One error cycle; exp is the message pulse expected one cycle later.
  task automatic err(input logic [3:0] ev, input logic [3:0] en, input logic exp);
    err_event_in = ev;
    err_enable_in = en;
    @(negedge mclk_in);
    err_event_in = 4'h0;
    chk({15'h0000, syserr_msg_out}, {15'h0000, exp});
    @(negedge mclk_in);
  endtask : err

  // Master cycle and pipelined request together; exp is {accept, abort, pipe}.
  task automatic frame(input logic range_ok, input logic [2:0] exp);
    frame_start_in = 1'b1;
    frame_range_ok_in = range_ok;
    pipe_req_in = 1'b1;
    @(negedge mclk_in);
    frame_start_in = 1'b0;
    pipe_req_in = 1'b0;
    chk({13'h0000, frame_accept_out, frame_master_abort_out, pipe_accept_out}, {13'h0000, exp});
    @(negedge mclk_in);
  endtask : frame

  // Host cycle against the windows; exp is {mem hit, io hit}.
  task automatic host(input logic is_io, input logic [31:0] addr, input logic [1:0] exp);
    host_req_in = 1'b1;
    host_is_io_in = is_io;
    host_addr_in = addr;
    @(negedge mclk_in);
    host_req_in = 1'b0;
    chk({14'h0000, mem_hit_out, io_hit_out}, {14'h0000, exp});
    @(negedge mclk_in);
  endtask : host

  // Main sequence of scenarios.
  initial begin
    repeat (8) @(negedge mclk_in);
    rst_in = 1'b0;
    @(negedge mclk_in);
    // Reset values of command and status, and an unmapped offset.
    cfg_rd(BPC_CMD_OFFSET, 16'h0000);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED);
    cfg_rd(8'h08, 16'h0000);
    // Master cycles are aborted while the master gate is clear; pipelined ones still pass.
    frame(1'b1, 3'b011);
    // Writing all ones leaves only the writable bits set.
    cfg_wr(BPC_CMD_OFFSET, 2'h3, 16'hFFFF);
    cfg_rd(BPC_CMD_OFFSET, 16'hFFFF & BPC_CMD_RW_MASK);
    cfg_rd(BPC_CMD_OFFSET, 16'h0107);
    chk({13'h0000, bus_master_enable_out, memory_decode_enable_out, io_decode_enable_out},
        16'h0007);
    cfg_wr(BPC_CMD_OFFSET, 2'h3, 16'hFEF8);
    cfg_rd(BPC_CMD_OFFSET, 16'h0000);
    cfg_rd(BPC_CMD_OFFSET, 16'h0000);
    // Byte enables touch one byte at a time.
    cfg_wr(BPC_CMD_OFFSET, 2'h3, 16'h0107);
    cfg_wr(BPC_CMD_OFFSET, 2'h1, 16'h0000);
    cfg_rd(BPC_CMD_OFFSET, 16'h0100);
    cfg_wr(BPC_CMD_OFFSET, 2'h2, 16'h0000);
    cfg_rd(BPC_CMD_OFFSET, 16'h0000);
    // Gate clear: no message, flag stays clear.
    err(4'hF, 4'hF, 1'b0);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED);
    // Gate set: only individually enabled conditions send a message.
    cfg_wr(BPC_CMD_OFFSET, 2'h2, 16'h0100);
    err(4'h5, 4'hA, 1'b0);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED);
    err(4'h4, 4'hC, 1'b1);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED | 16'h4000);
    cfg_rd(BPC_CMD_OFFSET, 16'h0100);
    // Writing one to the flag clears it; writing zero does not.
    cfg_wr(BPC_STS_OFFSET, 2'h2, 16'h0000);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED | 16'h4000);
    cfg_wr(BPC_STS_OFFSET, 2'h2, 16'h4000);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED);
    // An error and a clearing write in the same cycle: the set must win.
    err_event_in = 4'h4;
    cfg_in = '{1'b1, 1'b0, 2'h2, BPC_STS_OFFSET, 16'h4000};
    @(negedge mclk_in);
    err_event_in = 4'h0;
    cfg_in = '0;
    chk({15'h0000, syserr_msg_out}, 16'h0001);
    @(negedge mclk_in);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED | 16'h4000);
    // Master gate set: accept inside a valid range, abort outside.
    cfg_wr(BPC_CMD_OFFSET, 2'h1, 16'h0004);
    frame(1'b1, 3'b101);
    frame(1'b0, 3'b011);
    // Decode gates clear: nothing hits.
    host(1'b0, 32'h0000_1000, 2'b00);
    host(1'b1, 32'h0000_0100, 2'b00);
    // Memory gate only: memory window at both edges, prefetchable window at its top, I/O still off.
    cfg_wr(BPC_CMD_OFFSET, 2'h1, 16'h0002);
    host(1'b0, 32'h0000_1000, 2'b10);
    host(1'b0, 32'h0000_1FFF, 2'b10);
    host(1'b0, 32'h0000_8FFF, 2'b10);
    host(1'b0, 32'h0000_2000, 2'b00);
    host(1'b1, 32'h0000_0100, 2'b00);
    // I/O gate only: I/O window at its edges, memory off.
    cfg_wr(BPC_CMD_OFFSET, 2'h1, 16'h0001);
    host(1'b1, 32'h0000_0100, 2'b01);
    host(1'b1, 32'h0000_01FF, 2'b01);
    host(1'b1, 32'h0000_0200, 2'b00);
    host(1'b0, 32'h0000_8000, 2'b00);
    // A second reset in mid-run clears every enable and the master gate.
    cfg_wr(BPC_CMD_OFFSET, 2'h3, 16'h0107);
    rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    cfg_rd(BPC_CMD_OFFSET, 16'h0000);
    cfg_rd(BPC_STS_OFFSET, BPC_STS_FIXED);
    frame(1'b1, 3'b011);
    report_and_stop();
  end

  // Watchdog sized well beyond the roughly 110 cycles the sequence takes.
  initial begin
    repeat (2000) @(posedge mclk_in);
    err_count++;
    report_and_stop();
  end

endmodule : bpc_command_tb
